/* logic/pcs_regs_pkg.sv */
// Package: register map, field positions and reset values of the PCS error and fault bank
package pcs_regs_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [11:0] idx_framing = 12'h015;
	localparam logic [11:0] idx_parity = 12'h016;
	localparam logic [11:0] idx_hw_err = 12'h017;
	localparam logic [11:0] idx_ber = 12'h018;
	localparam logic [11:0] idx_test = 12'h019;
	localparam logic [11:0] idx_tally = 12'h01a;
	localparam logic [11:0] idx_fseq = 12'h01b;
	localparam logic [11:0] idx_phy_rst = 12'h01d;
	localparam logic [11:0] idx_mac_rst = 12'h121;
	localparam logic [11:0] idx_fault_cfg = 12'h122;

	localparam int lane_count = 20;
	localparam int hw_err_width = 9;

	// Field positions
	localparam int framing_any_bit = 31;
	localparam int ber_enable_bit = 1;
	localparam int ber_high_bit = 0;
	localparam int test_tx_bit = 0;
	localparam int test_rx_bit = 1;
	localparam int test_clear_bit = 2;
	localparam int fseq_enable_bit = 0;
	localparam int remote_status_bit = 5;
	localparam int local_status_bit = 4;
	localparam int remote_cfg_lsb = 2;
	localparam int local_cfg_lsb = 0;

	// Reset value and tally saturation limit
	localparam logic [31:0] reg_reset = 32'h0000_0000;
	localparam logic [31:0] tally_max = 32'hffff_ffff;

	// Transmit action chosen on a fault
	typedef enum logic [1:0] {
		tx_normal,
		tx_idle,
		tx_remote_fault
	} fault_action_t;

endpackage

/* logic/sync_flag.sv */
// Module: three-stage synchroniser for a vector of flags from outside the pclk domain
`timescale 1ns/10ps
module sync_flag
	import pcs_regs_pkg::*;
#(
	parameter int width = 1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Data
	input wire logic [width-1:0] async_in,
	output logic [width-1:0] sync_out
);

	logic [width-1:0] stage1_reg;
	logic [width-1:0] stage2_reg;
	logic [width-1:0] stage3_reg;

	// Stage one feeds only stage two; a change counts once two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
			sync_out <= '0;
		end else if (clk_en) begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			for (int i = 0; i < width; i++) begin
				if (stage2_reg[i] == stage3_reg[i]) begin
					sync_out[i] <= stage3_reg[i];
				end
			end
		end
	end

endmodule // sync_flag

/* logic/sat_tally.sv */
// Module: saturating 32-bit error tally with held clear
`timescale 1ns/10ps
module sat_tally
	import pcs_regs_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Control
	input wire logic clear,
	input wire logic count_en,
	input wire logic error,
	// Value
	output logic [31:0] tally
);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tally <= reg_reset;
		end else if (clk_en) begin
			if (clear) begin
				tally <= reg_reset;
			end else if (count_en && error && tally != tally_max) begin
				tally <= tally + 32'h0000_0001;
			end
		end
	end

endmodule // sat_tally

/* logic/pcs_error_test_fault_regs.sv */
// Module: APB register bank for PCS error flags, BER, test pattern and fault signalling
//
// Behaviour
// - Twenty per-lane framing flags, clear on read
// - Bit 31 summarises any lane framing error
// - Twenty per-lane parity flags, clear on read
// - Bits 8 and 7 report phase compensation
// - Bit 6 reports deskew failure
// - Bits 5 and 2 report section parity
// - Bits 4 and 3 report receive FIFO faults
// - Bits 1 and 0 report transmit FIFO faults
// - Error_rate_watch runs only while enabled
// - Bit 0 shows high bit error rate
// - Bits 0 and 1 enable test modes
// - Bit 2 clears the test tally
// - Saturating 32-bit test pattern error tally
// - Enable bit gates remote fault sequence
// - Bits 5 and 4 show fault status
// - Remote fault field picks transmit action
// - Local fault field picks transmit action
// - Writing one starts that reset
// - PHY reset bits: PMA, PCS tx, rx
// - MAC reset bits: MAC tx, rx
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
module pcs_error_test_fault_regs
	import pcs_regs_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Lane error events, pulses in pclk domain
	input wire logic [19:0] framing_err_evt,
	input wire logic [19:0] parity_err_evt,
	// Hardware error levels from other clock domains
	input wire logic [8:0] hw_err_in,
	// Error_rate_watch interface
	input wire logic high_ber_in,
	output logic error_rate_watch_en,
	// Test pattern
	input wire logic test_pattern_err,
	output logic tx_test_en,
	output logic rx_test_en,
	// Link fault
	input wire logic remote_fault_in,
	input wire logic local_fault_in,
	output logic fault_seq_en,
	output logic [1:0] tx_fault_action,
	// Resets
	output logic pma_reset,
	output logic pcs_tx_reset,
	output logic pcs_rx_reset,
	output logic mac_tx_reset,
	output logic mac_rx_reset
);

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode

	logic [11:0] index;
	logic word_ok;
	logic mapped;
	logic wr_en;
	logic rd_en;

	assign index = paddr[13:2];
	assign word_ok = paddr[1:0] == 2'h0;

	function automatic logic is_mapped(input logic [11:0] idx);
		is_mapped = (idx == idx_framing) || (idx == idx_parity) || (idx == idx_hw_err) ||
			(idx == idx_ber) || (idx == idx_test) || (idx == idx_tally) ||
			(idx == idx_fseq) || (idx == idx_phy_rst) || (idx == idx_mac_rst) ||
			(idx == idx_fault_cfg);
	endfunction

	function automatic fault_action_t decode_action(input logic [1:0] cfg);
		unique case (cfg)
			2'h1: decode_action = tx_idle;
			2'h3: decode_action = tx_remote_fault;
			default: decode_action = tx_normal;
		endcase
	endfunction

	// Single wait-free access phase keeps the bank simple
	assign mapped = word_ok && is_mapped(index);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_en = clk_en && psel && penable && pwrite && mapped;
	assign rd_en = clk_en && psel && penable && !pwrite && mapped;

	////////////////////////////////////////////////////////////////////////////////
	// Synchronised status inputs

	logic [8:0] hw_err_sync;
	logic [2:0] stat_sync;

	sync_flag #(.width(hw_err_width)) u_hw_sync (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.async_in(hw_err_in),
		.sync_out(hw_err_sync)
	);

	sync_flag #(.width(3)) u_stat_sync (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.async_in({high_ber_in, remote_fault_in, local_fault_in}),
		.sync_out(stat_sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clear-on-read lane flags

	logic [19:0] framing_reg;
	logic framing_any_reg;
	logic [19:0] parity_reg;
	logic rd_framing;
	logic rd_parity;

	assign rd_framing = rd_en && index == idx_framing;
	assign rd_parity = rd_en && index == idx_parity;

	// Set wins over the read clear so an event in the read cycle stays visible
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			framing_reg <= '0;
			framing_any_reg <= 1'b0;
		end else if (clk_en) begin
			framing_reg <= (rd_framing ? 20'h0_0000 : framing_reg) | framing_err_evt;
			framing_any_reg <= (rd_framing ? 1'b0 : framing_any_reg) | (|framing_err_evt);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			parity_reg <= '0;
		end else if (clk_en) begin
			parity_reg <= (rd_parity ? 20'h0_0000 : parity_reg) | parity_err_evt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers

	logic ber_en_reg;
	logic [2:0] test_reg;
	logic fseq_reg;
	logic [3:0] fault_cfg_reg;
	logic [2:0] phy_rst_reg;
	logic [1:0] mac_rst_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ber_en_reg <= 1'b0;
			test_reg <= '0;
			fseq_reg <= 1'b0;
			fault_cfg_reg <= '0;
			phy_rst_reg <= '0;
			mac_rst_reg <= '0;
		end else if (wr_en) begin
			unique case (index)
				idx_ber: ber_en_reg <= pwdata[ber_enable_bit];
				idx_test: test_reg <= pwdata[2:0];
				idx_fseq: fseq_reg <= pwdata[fseq_enable_bit];
				idx_fault_cfg: fault_cfg_reg <= pwdata[3:0];
				idx_phy_rst: phy_rst_reg <= pwdata[2:0];
				idx_mac_rst: mac_rst_reg <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	assign error_rate_watch_en = ber_en_reg;
	assign tx_test_en = test_reg[test_tx_bit];
	assign rx_test_en = test_reg[test_rx_bit];
	assign fault_seq_en = fseq_reg;
	// Resets follow the bits; software sequences them, PHY before MAC
	assign pma_reset = phy_rst_reg[2];
	assign pcs_tx_reset = phy_rst_reg[1];
	assign pcs_rx_reset = phy_rst_reg[0];
	assign mac_tx_reset = mac_rst_reg[1];
	assign mac_rx_reset = mac_rst_reg[0];

	////////////////////////////////////////////////////////////////////////////////
	// BER status, test tally

	logic high_ber;
	logic [31:0] tally;

	// High BER only reported while monitor runs
	assign high_ber = ber_en_reg & stat_sync[2];

	sat_tally u_tally (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.clear(test_reg[test_clear_bit]),
		.count_en(test_reg[test_rx_bit]),
		.error(test_pattern_err),
		.tally(tally)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Fault action

	logic remote_fault;
	logic local_fault;
	fault_action_t action_next;
	fault_action_t action_reg;

	assign remote_fault = stat_sync[1];
	assign local_fault = stat_sync[0];

	// Remote fault takes priority; sequence suppressed while enable is clear
	always_comb begin
		action_next = tx_normal;
		if (remote_fault) begin
			action_next = decode_action(fault_cfg_reg[3:2]);
		end else if (local_fault) begin
			action_next = decode_action(fault_cfg_reg[1:0]);
		end
		if (action_next == tx_remote_fault && !fseq_reg) begin
			action_next = tx_idle;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			action_reg <= tx_normal;
		end else if (clk_en) begin
			action_reg <= action_next;
		end
	end

	assign tx_fault_action = action_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Read mux

	logic [31:0] rd_next;

	always_comb begin
		rd_next = reg_reset;
		unique case (index)
			idx_framing: begin
				rd_next[19:0] = framing_reg;
				rd_next[framing_any_bit] = framing_any_reg;
			end
			idx_parity: rd_next[19:0] = parity_reg;
			idx_hw_err: rd_next[8:0] = hw_err_sync;
			idx_ber: begin
				rd_next[ber_enable_bit] = ber_en_reg;
				rd_next[ber_high_bit] = high_ber;
			end
			idx_test: rd_next[2:0] = test_reg;
			idx_tally: rd_next = tally;
			idx_fseq: rd_next[fseq_enable_bit] = fseq_reg;
			idx_phy_rst: rd_next[2:0] = phy_rst_reg;
			idx_mac_rst: rd_next[1:0] = mac_rst_reg;
			idx_fault_cfg: begin
				rd_next[3:0] = fault_cfg_reg;
				rd_next[remote_status_bit] = remote_fault;
				rd_next[local_status_bit] = local_fault;
			end
			default: rd_next = reg_reset;
		endcase
		if (!word_ok) begin
			rd_next = reg_reset;
		end
	end

	// Data captured in the setup cycle so it is stable during the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= reg_reset;
		end else if (clk_en && psel && !penable) begin
			prdata <= rd_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence framing_read_s;
		rd_framing && framing_err_evt == 20'h0_0000;
	endsequence

	framing_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		framing_read_s |=> framing_reg == 20'h0_0000 || !$past(clk_en))
		else $error("framing flags not cleared by read");

	framing_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && framing_err_evt != 20'h0_0000 |=> (framing_reg & $past(framing_err_evt)) == $past(framing_err_evt))
		else $error("framing event lost");

	framing_any_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && |framing_err_evt |=> framing_any_reg)
		else $error("summary framing flag not set");

	parity_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && parity_err_evt != 20'h0_0000 |=> (parity_reg & $past(parity_err_evt)) == $past(parity_err_evt))
		else $error("parity event lost");

	ber_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ber_en_reg |-> !high_ber)
		else $error("high BER shown while monitor off");

	tally_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && test_reg[test_clear_bit] |=> tally == 32'h0000_0000)
		else $error("tally not held at zero");

	tally_sat_a: assert property (@(posedge pclk) disable iff (!presetn)
		tally == tally_max && !test_reg[test_clear_bit] |=> tally == tally_max)
		else $error("tally wrapped");

	fault_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
		!fseq_reg |=> action_reg != tx_remote_fault || $past(fseq_reg))
		else $error("fault sequence sent while disabled");

	reset_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && index == idx_phy_rst && pwdata[2] |=> pma_reset)
		else $error("PMA reset not started");

	sequence parity_read_s;
		rd_parity && parity_err_evt == 20'h0_0000;
	endsequence

	parity_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		parity_read_s |=> parity_reg == 20'h0_0000)
		else $error("parity flags not cleared by read");

	// A frozen clock enable must hold the per-lane framing and parity flags and the tally
	freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!clk_en |=> $stable(framing_reg) && $stable(parity_reg) && $stable(tally))
		else $error("state changed while clock enable low");

endmodule // pcs_error_test_fault_regs

/* verification/tb_top.sv */
// Testbench for the PCS error, test pattern and fault register bank
`timescale 1ns/10ps
module tb_top
	import pcs_regs_pkg::*;
;
	////////////////////////////////////////////////////////////////
	logic pclk, presetn, clk_en, psel, penable, pwrite;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr;
	logic [19:0] framing_err_evt, parity_err_evt;
	logic [8:0] hw_err_in, outs;
	logic high_ber_in, error_rate_watch_en, test_pattern_err, tx_test_en, rx_test_en;
	logic remote_fault_in, local_fault_in, fault_seq_en;
	logic [1:0] tx_fault_action;
	logic pma_reset, pcs_tx_reset, pcs_rx_reset, mac_tx_reset, mac_rx_reset;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	assign outs = {pma_reset, pcs_tx_reset, pcs_rx_reset, mac_tx_reset, mac_rx_reset,
		error_rate_watch_en, tx_test_en, rx_test_en, fault_seq_en};
	pcs_error_test_fault_regs pcs_error_test_fault_regs_i (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .framing_err_evt(framing_err_evt), .parity_err_evt(parity_err_evt),
		.hw_err_in(hw_err_in), .high_ber_in(high_ber_in), .error_rate_watch_en(error_rate_watch_en),
		.test_pattern_err(test_pattern_err), .tx_test_en(tx_test_en), .rx_test_en(rx_test_en),
		.remote_fault_in(remote_fault_in), .local_fault_in(local_fault_in),
		.fault_seq_en(fault_seq_en), .tx_fault_action(tx_fault_action), .pma_reset(pma_reset),
		.pcs_tx_reset(pcs_tx_reset), .pcs_rx_reset(pcs_rx_reset),
		.mac_tx_reset(mac_tx_reset), .mac_rx_reset(mac_rx_reset)
	);
	////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic give_verdict();
		$display("Counts: %0d checked, %0d mismatches", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task automatic xfer(input logic wr, input logic [11:0] idx, input logic [1:0] lo,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, lo};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		logic [31:0] rd;
		logic err;
		xfer(1'b1, idx, 2'b00, d, rd, err);
		// The write lands on the access edge; let it settle before outputs are compared
		@(posedge pclk);
	endtask
	task automatic rd_check(input string what, input logic [11:0] idx, input logic [31:0] exp);
		logic [31:0] rd;
		logic err;
		xfer(1'b0, idx, 2'b00, 32'h0, rd, err);
		check(what, exp, rd);
	endtask
	task automatic pulse(input logic [19:0] f, input logic [19:0] p, input logic t);
		@(posedge pclk);
		framing_err_evt <= f;
		parity_err_evt <= p;
		test_pattern_err <= t;
		@(posedge pclk);
		framing_err_evt <= 20'h0;
		parity_err_evt <= 20'h0;
		test_pattern_err <= 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		logic [11:0] map [10];
		logic [7:0] act_tbl;
		logic [31:0] rd;
		logic err;
		map = '{idx_framing, idx_parity, idx_hw_err, idx_ber, idx_test, idx_tally, idx_fseq,
			idx_phy_rst, idx_mac_rst, idx_fault_cfg};
		act_tbl = 8'b10_00_01_00;
		{presetn, clk_en, psel, penable, pwrite, paddr, pwdata} = '0;
		{framing_err_evt, parity_err_evt, hw_err_in, test_pattern_err} = '0;
		{high_ber_in, remote_fault_in, local_fault_in} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		clk_en <= 1'b1;
		for (int i = 0; i < 10; i++) rd_check("reset value", map[i], 32'h0);
		check("reset outputs", 32'h0, {23'h0, outs});
		xfer(1'b0, 12'hffe, 2'b00, 32'h0, rd, err);
		check("unmapped err", 32'h1, {31'h0, err});
		check("unmapped data", 32'h0, rd);
		check("pready", 32'h1, {31'h0, pready});
		$display("Test reset and map done");
		wr(idx_phy_rst, 32'h7);
		check("phy reset", 32'h1c0, {23'h0, outs});
		wr(idx_mac_rst, 32'h3);
		check("mac reset", 32'h1f0, {23'h0, outs});
		rd_check("mac readback", idx_mac_rst, 32'h3);
		wr(idx_mac_rst, 32'h0);
		check("mac release", 32'h1c0, {23'h0, outs});
		wr(idx_phy_rst, 32'h0);
		check("phy release", 32'h0, {23'h0, outs});
		$display("Test reset sequence done");
		pulse(20'h80001, 20'h00010, 1'b0);
		pulse(20'h0, 20'h80000, 1'b0);
		rd_check("framing", idx_framing, 32'h8008_0001);
		rd_check("framing cleared", idx_framing, 32'h0);
		rd_check("parity", idx_parity, 32'h0008_0010);
		rd_check("parity cleared", idx_parity, 32'h0);
		// Event lands on the access edge of a clearing read and must survive it
		fork
			rd_check("framing in read", idx_framing, 32'h0);
			begin
				idle(2);
				framing_err_evt <= 20'h00002;
				@(posedge pclk);
				framing_err_evt <= 20'h0;
			end
		join
		rd_check("framing kept", idx_framing, 32'h8000_0002);
		// Nothing is recorded while the clock enable is low
		clk_en <= 1'b0;
		pulse(20'h00004, 20'h00004, 1'b0);
		clk_en <= 1'b1;
		rd_check("framing frozen", idx_framing, 32'h0);
		rd_check("parity frozen", idx_parity, 32'h0);
		$display("Test lane flags done");
		hw_err_in <= 9'h1a5;
		wr(idx_hw_err, 32'h1ff);
		idle(4);
		rd_check("hw err a", idx_hw_err, 32'h1a5);
		hw_err_in <= 9'h05a;
		idle(6);
		rd_check("hw err b", idx_hw_err, 32'h05a);
		$display("Test hw errors done");
		high_ber_in <= 1'b1;
		idle(6);
		rd_check("ber off", idx_ber, 32'h0);
		wr(idx_ber, 32'hffff_ffff);
		check("ber enable", 32'h8, {23'h0, outs});
		rd_check("ber high", idx_ber, 32'h3);
		high_ber_in <= 1'b0;
		idle(6);
		rd_check("ber low", idx_ber, 32'h2);
		wr(idx_ber, 32'h0);
		rd_check("ber cleared", idx_ber, 32'h0);
		$display("Test ber done");
		wr(idx_test, 32'h3);
		check("test enables", 32'h6, {23'h0, outs});
		repeat (5) pulse(20'h0, 20'h0, 1'b1);
		rd_check("tally five", idx_tally, 32'h5);
		wr(idx_test, 32'h6);
		pulse(20'h0, 20'h0, 1'b1);
		rd_check("tally held", idx_tally, 32'h0);
		wr(idx_test, 32'h2);
		pulse(20'h0, 20'h0, 1'b1);
		rd_check("tally resumed", idx_tally, 32'h1);
		rd_check("test readback", idx_test, 32'h2);
		$display("Test pattern tally done");
		wr(idx_fseq, 32'h1);
		check("seq enable", 32'h3, {23'h0, outs});
		remote_fault_in <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(idx_fault_cfg, i << 2);
			idle(6);
			check("remote action", act_tbl[2*i +: 2], tx_fault_action);
			rd_check("remote cfg", idx_fault_cfg, 32'h20 | (i << 2));
		end
		remote_fault_in <= 1'b0;
		local_fault_in <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(idx_fault_cfg, i);
			idle(6);
			check("local action", act_tbl[2*i +: 2], tx_fault_action);
			rd_check("local cfg", idx_fault_cfg, 32'h10 | i);
		end
		wr(idx_fseq, 32'h0);
		idle(3);
		check("seq gated", 32'h1, tx_fault_action);
		$display("Test fault signalling done");
		give_verdict();
	end
endmodule // tb_top
